// >>> shading_pkg.sv
// Package with constants and types for the pixel shading correction block
package shading_pkg;
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned SAVE_TIME_S = 120;
   localparam int unsigned RELOAD_TIME_S = 25;
   localparam longint unsigned SAVE_CYCLES = longint'(SAVE_TIME_S) * CLK_HZ;
   localparam longint unsigned RELOAD_CYCLES = longint'(RELOAD_TIME_S) * CLK_HZ;
   localparam int unsigned NUM_FRAMES = 8;
   localparam int unsigned FRAME_SHIFT = 3;
   localparam int unsigned GAIN_FRAC = 8;
   localparam logic [9:0] GAIN_UNITY = 10'h100;
   localparam logic [9:0] GAIN_MAX = 10'h200;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam int unsigned MODE_DARK_BIT = 0;
   localparam int unsigned MODE_GAIN_BIT = 1;

   typedef enum logic [2:0] {
      ST_BOOT = 3'b000,
      ST_IDLE = 3'b001,
      ST_CAPTURE = 3'b010,
      ST_REF = 3'b011,
      ST_CALC = 3'b100,
      ST_SAVE = 3'b101
   } state_t;

   typedef struct packed {
      logic [1:0] mode;
      logic generate_req;
      logic save_req;
      logic free_run;
      logic external_exposure_trigger;
   } ctrl_t;

   typedef struct packed {
      logic ready;
      logic busy;
      logic table_saved;
      logic [3:0] frames_seen;
   } status_t;
endpackage : shading_pkg

// >>> pixel_shading_correction_gen.sv
// Shading correction table generation and per-pixel correction
`timescale 1ns/100ps
module pixel_shading_correction_gen #(
   parameter int PIX_W = 10,
   parameter int COLS = 16,
   parameter int ROWS = 16,
   parameter int CHANNELS = 1,
   parameter int FREE_RUN_GAP = 64,
   parameter longint unsigned SAVE_CYC = shading_pkg::SAVE_CYCLES,
   parameter longint unsigned RELOAD_CYC = shading_pkg::RELOAD_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Host control and status
   input wire shading_pkg::ctrl_t ctrl,
   input wire logic store_standard_set,
   input wire logic [$clog2(COLS)-1:0] roi_x0,
   input wire logic [$clog2(COLS)-1:0] roi_x1,
   input wire logic [$clog2(ROWS)-1:0] roi_y0,
   input wire logic [$clog2(ROWS)-1:0] roi_y1,
   output shading_pkg::status_t status,
   // Sensor pixel stream in
   input wire logic pix_valid,
   input wire logic pix_sof,
   input wire logic [PIX_W-1:0] pix_data,
   input wire logic [$clog2(COLS)-1:0] pix_x,
   input wire logic [$clog2(ROWS)-1:0] pix_y,
   output logic frame_start_req,
   // Corrected pixel stream out
   output logic out_valid,
   output logic [PIX_W-1:0] out_data
);
   import shading_pkg::*;

   localparam int N = COLS * ROWS;
   localparam int AW = $clog2(N);
   localparam int SW = PIX_W + FRAME_SHIFT;
   localparam int XW = $clog2(COLS);
   localparam int YW = $clog2(ROWS);
   localparam logic [PIX_W-1:0] FULL = '1;

   // Tables: reset to zero (gains to unity), so they act as volatile storage
   logic [SW-1:0] acc_r [N];
   logic [PIX_W-1:0] offs_r [N];
   logic [9:0] gain_r [N];
   logic [PIX_W-1:0] ch_max_r [CHANNELS];

   state_t state_r;
   logic [63:0] timer_r;
   logic [3:0] frames_r;
   logic [15:0] pace_r;
   logic [AW:0] idx_r;
   logic in_frame_r;
   logic saved_r;
   logic persist_r;
   logic ext_s1_r, ext_s2_r, ext_s3_r;
   logic gen_s1_r, gen_s2_r, gen_s3_r;
   logic sav_s1_r, sav_s2_r, sav_s3_r;

   function automatic logic [AW-1:0] pix_addr(input logic [$clog2(COLS)-1:0] x, input logic [$clog2(ROWS)-1:0] y);
      pix_addr = AW'(int'(y) * COLS + int'(x));
   endfunction : pix_addr

   function automatic logic in_roi(input logic [AW-1:0] a);
      int x;
      int y;
      x = int'(a) % COLS;
      y = int'(a) / COLS;
      in_roi = (x >= int'(roi_x0)) && (x <= int'(roi_x1)) && (y >= int'(roi_y0)) && (y <= int'(roi_y1));
   endfunction : in_roi

   function automatic int chan_of(input logic [AW-1:0] a);
      chan_of = (int'(a) % COLS) % CHANNELS;
   endfunction : chan_of

   // Host strobes and trigger come from other logic/pins: synchronise, then edge-detect
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         {ext_s1_r, ext_s2_r, ext_s3_r} <= 3'h0;
         {gen_s1_r, gen_s2_r, gen_s3_r} <= 3'h0;
         {sav_s1_r, sav_s2_r, sav_s3_r} <= 3'h0;
      end else begin
         ext_s1_r <= ctrl.external_exposure_trigger;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
         gen_s1_r <= ctrl.generate_req;
         gen_s2_r <= gen_s1_r;
         gen_s3_r <= gen_s2_r;
         sav_s1_r <= ctrl.save_req;
         sav_s2_r <= sav_s1_r;
         sav_s3_r <= sav_s2_r;
      end
   end

   wire ext_rise = ext_s2_r & ~ext_s3_r;
   wire gen_rise = gen_s2_r & ~gen_s3_r;
   wire save_rise = sav_s2_r & ~sav_s3_r;
   wire last_idx = (idx_r == (AW+1)'(N - 1));

   // Persistence flags for the non-volatile side, cleared on reset like the tables; one saved file only
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         saved_r <= 1'b0;
         persist_r <= 1'b0;
      end else begin
         if (state_r == ST_SAVE && timer_r == 64'h0)
            saved_r <= 1'b1;
         // Storing the standard set only records the enable, never table data
         if (store_standard_set)
            persist_r <= (ctrl.mode != MODE_OFF);
      end
   end

   // Sequencer
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_r <= ST_BOOT;
         timer_r <= 64'h0;
         frames_r <= 4'h0;
         idx_r <= '0;
         in_frame_r <= 1'b0;
      end else begin
         case (state_r)
            ST_BOOT: begin
               // Reload wait applies only when a file, enable and standard set all exist
               if (!(saved_r && persist_r) || timer_r >= RELOAD_CYC - 1) begin
                  state_r <= ST_IDLE;
                  timer_r <= 64'h0;
               end else
                  timer_r <= timer_r + 64'h1;
            end
            ST_IDLE: begin
               if (gen_rise) begin
                  state_r <= ST_CAPTURE;
                  frames_r <= 4'h0;
                  timer_r <= 64'h0;
                  in_frame_r <= 1'b0;
               end else if (save_rise) begin
                  state_r <= ST_SAVE;
                  timer_r <= SAVE_CYC - 1;
               end
            end
            ST_CAPTURE: begin
               // A frame counts only from its first pixel, so a frame cut by the start is skipped
               if (pix_valid && pix_sof)
                  in_frame_r <= 1'b1;
               if (pix_valid && in_frame_r && pix_x == XW'(COLS - 1) && pix_y == YW'(ROWS - 1)) begin
                  in_frame_r <= 1'b0;
                  frames_r <= frames_r + 4'h1;
                  if (frames_r == 4'(NUM_FRAMES - 1)) begin
                     state_r <= ST_REF;
                     idx_r <= '0;
                  end
               end
            end
            ST_REF: begin
               idx_r <= last_idx ? '0 : idx_r + 1'b1;
               if (last_idx)
                  state_r <= ST_CALC;
            end
            ST_CALC: begin
               idx_r <= idx_r + 1'b1;
               if (last_idx)
                  state_r <= ST_IDLE;
            end
            ST_SAVE: begin
               // Long non-volatile write; only one file is ever held
               if (timer_r == 64'h0)
                  state_r <= ST_IDLE;
               else
                  timer_r <= timer_r - 64'h1;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Frame pacing runs in every state after boot: the image stream never stops for generation
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pace_r <= 16'h0;
         frame_start_req <= 1'b0;
      end else begin
         frame_start_req <= 1'b0;
         if (state_r == ST_BOOT || !ctrl.free_run || pace_r >= 16'(FREE_RUN_GAP))
            pace_r <= 16'h0;
         else
            pace_r <= pace_r + 16'h1;
         if (state_r != ST_BOOT) begin
            if (ctrl.free_run && pace_r >= 16'(FREE_RUN_GAP))
               frame_start_req <= 1'b1;
            else if (!ctrl.free_run && ext_rise)
               frame_start_req <= 1'b1;
         end
      end
   end

   // Frame accumulation: sum of eight frames, only in the region of interest
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < N; i++)
            acc_r[i] <= '0;
      end else if (state_r == ST_IDLE && gen_rise) begin
         for (int i = 0; i < N; i++)
            acc_r[i] <= '0;
      end else if (state_r == ST_CAPTURE && pix_valid && (in_frame_r || pix_sof) &&
                   in_roi(pix_addr(pix_x, pix_y))) begin
         acc_r[pix_addr(pix_x, pix_y)] <= acc_r[pix_addr(pix_x, pix_y)] + SW'(pix_data);
      end
   end

   // Reference: brightest eight-frame average, kept per colour channel
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int c = 0; c < CHANNELS; c++)
            ch_max_r[c] <= '0;
      end else if (state_r == ST_CAPTURE) begin
         for (int c = 0; c < CHANNELS; c++)
            ch_max_r[c] <= '0;
      end else if (state_r == ST_REF) begin
         if (in_roi(idx_r[AW-1:0]) &&
             acc_r[idx_r[AW-1:0]][SW-1:FRAME_SHIFT] > ch_max_r[chan_of(idx_r[AW-1:0])])
            ch_max_r[chan_of(idx_r[AW-1:0])] <= acc_r[idx_r[AW-1:0]][SW-1:FRAME_SHIFT];
      end
   end

   // Table calculation; entries outside the region keep their earlier values
   logic [PIX_W-1:0] calc_avg;
   logic [PIX_W-1:0] calc_ref;
   logic [PIX_W+GAIN_FRAC-1:0] calc_q;
   always_comb begin
      calc_avg = acc_r[idx_r[AW-1:0]][SW-1:FRAME_SHIFT];
      // Read the finished maximum, so the last pixel of the scan is included
      calc_ref = ch_max_r[chan_of(idx_r[AW-1:0])];
      calc_q = (calc_avg == '0) ? '1 : ({calc_ref, GAIN_FRAC'(0)} / (PIX_W+GAIN_FRAC)'(calc_avg));
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < N; i++) begin
            offs_r[i] <= '0;
            gain_r[i] <= GAIN_UNITY;
         end
      end else if (state_r == ST_CALC && in_roi(idx_r[AW-1:0])) begin
         // Overwrite in place: new values take effect for the next pixel read
         offs_r[idx_r[AW-1:0]] <= calc_ref - calc_avg;
         // Gain range is capped at 2x, so pixels under half of reference stay short
         gain_r[idx_r[AW-1:0]] <= (calc_q > (PIX_W+GAIN_FRAC)'(GAIN_MAX)) ? GAIN_MAX :
                                  calc_q[9:0];
      end
   end

   // Output correction
   logic [PIX_W:0] sum_c;
   logic [PIX_W+10:0] prod_c;
   logic [AW-1:0] out_a;
   always_comb begin
      out_a = pix_addr(pix_x, pix_y);
      sum_c = {1'b0, pix_data};
      if (ctrl.mode[MODE_DARK_BIT])
         sum_c = sum_c + {1'b0, offs_r[out_a]};
      prod_c = (PIX_W+11)'(sum_c) << GAIN_FRAC;
      if (ctrl.mode[MODE_GAIN_BIT])
         prod_c = (PIX_W+11)'(sum_c) * (PIX_W+11)'(gain_r[out_a]);
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         out_valid <= 1'b0;
         out_data <= '0;
      end else begin
         out_valid <= pix_valid && state_r != ST_BOOT;
         out_data <= (prod_c[PIX_W+10:GAIN_FRAC] > (PIX_W+3)'(FULL)) ? FULL :
                     prod_c[PIX_W+GAIN_FRAC-1:GAIN_FRAC];
      end
   end

   always_comb begin
      status.ready = (state_r != ST_BOOT);
      status.busy = (state_r != ST_IDLE);
      status.table_saved = saved_r;
      status.frames_seen = frames_r;
   end
endmodule : pixel_shading_correction_gen

// >>> shading_sva.sv
// Port assertions for the shading correction block
`timescale 1ns/100ps
module shading_sva
   import shading_pkg::*;
#(parameter int PIX_W = 10) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Watched ports
   input wire shading_pkg::ctrl_t ctrl,
   input wire shading_pkg::status_t status,
   input wire logic pix_valid,
   input wire logic [PIX_W-1:0] pix_data,
   input wire logic frame_start_req,
   input wire logic out_valid,
   input wire logic [PIX_W-1:0] out_data
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   property p_out_valid;
      out_valid |-> $past(pix_valid) && status.ready;
   endproperty
   a_out_valid: assert property (p_out_valid) else $error("output without pixel");
   property p_pass;
      pix_valid && status.ready && ctrl.mode == MODE_OFF |=> out_valid && out_data == $past(pix_data);
   endproperty
   a_pass: assert property (p_pass) else $error("pixel altered with correction off");
   property p_gen_start;
      $rose(ctrl.generate_req) && status.ready && !status.busy |-> ##[1:5] status.busy;
   endproperty
   a_gen_start: assert property (p_gen_start) else $error("generation not started");
   property p_frames_max;
      status.frames_seen <= 4'h8;
   endproperty
   a_frames_max: assert property (p_frames_max) else $error("too many frames");
   property p_frames_step;
      status.frames_seen != $past(status.frames_seen) |->
         status.frames_seen == $past(status.frames_seen) + 4'h1 || status.frames_seen == 4'h0;
   endproperty
   a_frames_step: assert property (p_frames_step) else $error("frame count jumped");
   property p_capture_busy;
      status.busy && status.frames_seen != 4'h0 && status.frames_seen < 4'h8 |=> status.busy;
   endproperty
   a_capture_busy: assert property (p_capture_busy) else $error("idle before eight frames");
   property p_ready_hold;
      status.ready |=> status.ready;
   endproperty
   a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");
   property p_saved_hold;
      status.table_saved |=> status.table_saved;
   endproperty
   a_saved_hold: assert property (p_saved_hold) else $error("saved flag lost");
   property p_req_pulse;
      frame_start_req |=> !frame_start_req [*8];
   endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("frame request too close");
endmodule : shading_sva

bind pixel_shading_correction_gen shading_sva #(.PIX_W(PIX_W)) i_sva (.core_clk, .reset, .ctrl, .status,
   .pix_valid, .pix_data, .frame_start_req, .out_valid, .out_data);

// >>> sensor_model.sv
// Sensor readout model: one 4x4 frame per frame request
`timescale 1ns/100ps
module sensor_model (
   // Clock and control
   input wire logic core_clk,
   input wire logic frame_start_req,
   input wire logic [1:0] scene,
   // Pixel stream
   output logic pix_valid,
   output logic pix_sof,
   output logic [9:0] pix_data,
   output logic [1:0] pix_x,
   output logic [1:0] pix_y
);
   logic [4:0] idx = 5'h10;
   function automatic logic [9:0] pix_val(input logic [1:0] s, input logic [1:0] x, input logic [1:0] y);
      if (s == 2'h0)
         return x == 2'h0 ? 10'h200 : x == 2'h1 ? (y == 2'h3 ? 10'h064 : 10'h100) : 10'h12c;
      return x < 2'h2 ? 10'h064 : y == 2'h0 ? 10'h190 : 10'h0c8;
   endfunction : pix_val
   // Requests during a frame are dropped, as a real readout would
   always_ff @(posedge core_clk) begin
      if (frame_start_req && idx[4])
         idx <= 5'h0;
      else if (!idx[4])
         idx <= idx + 5'h1;
   end
   assign pix_valid = !idx[4];
   assign pix_sof = idx == 5'h0;
   assign pix_x = idx[1:0];
   assign pix_y = idx[3:2];
   // Idle data is inverted so a stale sample never passes
   assign pix_data = pix_valid ? pix_val(scene, pix_x, pix_y) : ~pix_val(scene, pix_x, pix_y);
endmodule : sensor_model

// >>> pixel_shading_correction_gen_tb.sv
// Testbench for the shading correction block
`timescale 1ns/100ps
module pixel_shading_correction_gen_tb;
   import shading_pkg::*;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   ctrl_t ctrl = '0;
   logic store_standard_set = 1'b0;
   logic [1:0] roi_x0 = 2'h0, roi_x1 = 2'h1, roi_y0 = 2'h0, roi_y1 = 2'h3, scene = 2'h0;
   status_t status;
   logic pix_valid, pix_sof, frame_start_req, out_valid, chk_en = 1'b0, pv_d = 1'b0;
   logic [9:0] pix_data, out_data, exp_d;
   logic [1:0] pix_x, pix_y;
   logic [9:0] off [4][4];
   logic [9:0] gn [4][4];
   int n_errors = 0, checks = 0, cyc = 0;
   localparam int CH = 2;

   pixel_shading_correction_gen #(.COLS(4), .ROWS(4), .CHANNELS(CH), .FREE_RUN_GAP(24), .SAVE_CYC(20),
      .RELOAD_CYC(20)) i_dut (
      .core_clk, .reset, .ctrl, .store_standard_set, .roi_x0, .roi_x1, .roi_y0, .roi_y1, .status,
      .pix_valid, .pix_sof, .pix_data, .pix_x, .pix_y, .frame_start_req, .out_valid, .out_data);
   sensor_model i_sensor (.core_clk, .frame_start_req, .scene, .pix_valid, .pix_sof, .pix_data, .pix_x, .pix_y);

   initial forever #10 core_clk = ~core_clk;

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out

   task automatic check(input logic [10:0] seen, input logic [10:0] want);
      checks++;
      if (seen !== want) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, want);
      end
   endtask : check

   function automatic logic [9:0] expect_px(logic [1:0] m, logic [1:0] x, logic [1:0] y, logic [9:0] v);
      int r;
      r = v + (m[MODE_DARK_BIT] ? off[x][y] : 0);
      if (m[MODE_GAIN_BIT])
         r = (r * gn[x][y]) >> 8;
      return r > 1023 ? 10'h3ff : 10'(r);
   endfunction : expect_px

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         close_out();
      end else begin
         if (chk_en && pv_d)
            check({out_valid, out_data}, {1'b1, exp_d});
         pv_d <= pix_valid;
         exp_d <= expect_px(ctrl.mode, pix_x, pix_y, pix_data);
      end
   end

   task automatic clear_model();
      for (int x = 0; x < 4; x++)
         for (int y = 0; y < 4; y++) begin
            off[x][y] = 10'h0;
            gn[x][y] = GAIN_UNITY;
         end
   endtask : clear_model

   // Reference is taken inside the region only, per colour channel (column mod CH)
   task automatic gen_model(input logic [1:0] s);
      int r [CH];
      int v;
      for (int c = 0; c < CH; c++)
         r[c] = 0;
      for (int x = roi_x0; x <= roi_x1; x++)
         for (int y = roi_y0; y <= roi_y1; y++) begin
            v = i_sensor.pix_val(s, 2'(x), 2'(y));
            r[x % CH] = v > r[x % CH] ? v : r[x % CH];
         end
      for (int x = roi_x0; x <= roi_x1; x++)
         for (int y = roi_y0; y <= roi_y1; y++) begin
            v = i_sensor.pix_val(s, 2'(x), 2'(y));
            off[x][y] = 10'(r[x % CH] - v);
            gn[x][y] = r[x % CH] * 256 / v > 512 ? GAIN_MAX : 10'(r[x % CH] * 256 / v);
         end
   endtask : gen_model

   task automatic run_modes();
      for (int m = 0; m < 4; m++) begin
         ctrl.mode <= 2'(m);
         do @(posedge core_clk); while (!pix_sof);
         chk_en <= 1'b1;
         repeat (16) @(posedge core_clk);
         chk_en <= 1'b0;
      end
   endtask : run_modes

   task automatic gen(input logic [1:0] s, input logic ext);
      ctrl.generate_req <= 1'b1;
      repeat (6) @(posedge core_clk);
      check({10'h0, status.busy}, 11'h1);
      ctrl.generate_req <= 1'b0;
      for (int i = 0; ext && i < 8; i++) begin
         if (i == 7)
            check({10'h0, status.busy}, 11'h1);
         ctrl.external_exposure_trigger <= 1'b1;
         repeat (4) @(posedge core_clk);
         ctrl.external_exposure_trigger <= 1'b0;
         repeat (36) @(posedge core_clk);
      end
      for (int w = 0; w < 2000 && status.busy; w++)
         @(posedge core_clk);
      check({10'h0, status.busy}, 11'h0);
      check({7'h0, status.frames_seen}, 11'h8);
      gen_model(s);
   endtask : gen

   initial begin
      clear_model();
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      ctrl.free_run <= 1'b1;
      repeat (3) @(posedge core_clk);
      check({10'h0, status.ready}, 11'h1);
      run_modes();
      gen(2'h0, 1'b0);
      run_modes();
      ctrl.free_run <= 1'b0;
      roi_x0 <= 2'h2;
      roi_x1 <= 2'h3;
      scene <= 2'h1;
      repeat (40) @(posedge core_clk);
      gen(2'h1, 1'b1);
      ctrl.free_run <= 1'b1;
      scene <= 2'h0;
      run_modes();
      ctrl.save_req <= 1'b1;
      repeat (6) @(posedge core_clk);
      check({10'h0, status.busy}, 11'h1);
      ctrl.save_req <= 1'b0;
      for (int w = 0; w < 200 && status.busy; w++)
         @(posedge core_clk);
      check({9'h0, status.table_saved, status.busy}, 11'h2);
      store_standard_set <= 1'b1;
      @(posedge core_clk);
      store_standard_set <= 1'b0;
      run_modes();
      reset <= 1'b1;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      clear_model();
      repeat (3) @(posedge core_clk);
      run_modes();
      close_out();
   end
endmodule : pixel_shading_correction_gen_tb
